// file: bench/mps_link_chk.sv
// Purpose: Concurrent checks on the host/module link
// Assumes: One ref_clk_i domain, nrst_i active low
// Notes: Press lengths arrive as parameters matching both ends
`timescale 1ns/100ps
`default_nettype none
module mps_link_chk import mps_pkg::*; #(
	parameter int unsigned ON_CYC = 8,
	parameter int unsigned OFF_CYC = 12,
	parameter int unsigned STABLE_CYC = 5
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Link signals
	input wire logic main_supply,
	input wire logic power_key_n,
	input wire logic radio_off_n,
	input wire logic cmd_valid,
	input wire mps_cmd_e cmd_code,
	input wire logic [2:0] cmd_arg,
	input wire logic cmd_ack,
	input wire logic cmd_err,
	input wire logic usb_remote_wake,
	input wire logic module_status
);
	logic [31:0] low_cnt_q;
	logic [31:0] sup_cnt_q;
	// Run lengths exceed what a repetition may unroll
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			low_cnt_q <= 32'h0;
			sup_cnt_q <= 32'h0;
		end else begin
			low_cnt_q <= power_key_n ? 32'h0 : low_cnt_q + 32'h1;
			sup_cnt_q <= main_supply ? sup_cnt_q + 32'h1 : 32'h0;
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	////////////////////////////////////////////////////////////////////////////////
	property p_key_len;
		$rose(power_key_n) |-> (low_cnt_q == ON_CYC) || (low_cnt_q == OFF_CYC);
	endproperty
	a_key_len: assert property (p_key_len) else $error("key press length wrong");
	property p_supply_first;
		$fell(power_key_n) |-> sup_cnt_q >= STABLE_CYC;
	endproperty
	a_supply_first: assert property (p_supply_first) else $error("key before supply settled");
	property p_turn_on;
		$rose(power_key_n) && low_cnt_q == ON_CYC |-> ##[0:2] module_status;
	endproperty
	a_turn_on: assert property (p_turn_on) else $error("module did not turn on");
	property p_turn_off;
		$rose(power_key_n) && low_cnt_q == OFF_CYC |-> ##[0:2] !module_status;
	endproperty
	a_turn_off: assert property (p_turn_off) else $error("module did not turn off");
	property p_cmd_answer;
		cmd_valid |=> cmd_ack != cmd_err;
	endproperty
	a_cmd_answer: assert property (p_cmd_answer) else $error("command not answered once");
	property p_no_stray;
		cmd_ack || cmd_err |-> $past(cmd_valid);
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("answer without command");
	property p_fun_bad;
		cmd_valid && cmd_code == CMD_FUN && !(cmd_arg inside {3'h0, 3'h1, 3'h4}) |=> cmd_err;
	endproperty
	a_fun_bad: assert property (p_fun_bad) else $error("bad level accepted");
	property p_sclk_bad;
		cmd_valid && cmd_code == CMD_SCLK && cmd_arg > 3'h1 |=> cmd_err;
	endproperty
	a_sclk_bad: assert property (p_sclk_bad) else $error("bad sleep argument accepted");
	property p_rf_blocked;
		cmd_valid && cmd_code == CMD_RF && !radio_off_n |=> cmd_err;
	endproperty
	a_rf_blocked: assert property (p_rf_blocked) else $error("radio command in airplane");
	property p_supply_hold;
		$fell(main_supply) |-> !$past(module_status);
	endproperty
	a_supply_hold: assert property (p_supply_hold) else $error("supply cut while on");
	property p_rwake_on;
		usb_remote_wake |-> module_status;
	endproperty
	a_rwake_on: assert property (p_rwake_on) else $error("remote wake while off");
	property p_key_release;
		$rose(module_status) |-> power_key_n;
	endproperty
	a_key_release: assert property (p_key_release) else $error("key held after turn-on");
endmodule : mps_link_chk
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Drives host registers and module events, checks both ends
// Assumes: Shortened press lengths on both ends
// Notes: Directed sequence, no random stimulus
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import mps_pkg::*;
	localparam int unsigned ON_N = 8;
	localparam int unsigned OFF_N = 12;
	localparam int unsigned ST_N = 5;
	logic ref_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq;
	logic [1:0] scenario = SCEN_UART;
	logic unsolicited_result = 1'b0;
	logic acq = 1'b0;
	logic combined = 1'b1;
	logic [1:0] pstate;
	logic [1:0] sstate;
	logic [2:0] fun;
	logic rf_en;
	logic sim_en;
	logic seen;
	logic [31:0] v;
	int mismatches = 0;
	int n_compared = 0;
	mps_link_if link();
	mps_host_ctl #(.ON_CYC(ON_N), .OFF_CYC(OFF_N), .STABLE_CYC(ST_N)) u_mps_host_ctl (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .irq_o(irq), .link(link));
	mps_module_dev #(.ON_CYC(ON_N), .OFF_CYC(OFF_N)) u_mps_module_dev (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .link(link), .scenario_i(scenario),
		.combined_i(combined), .urc_pending_i(unsolicited_result), .acq_done_i(acq), .power_state_o(pstate),
		.fun_level_o(fun), .rf_enable_o(rf_en), .sim_enable_o(sim_en), .satnav_state_o(sstate));
	mps_link_chk #(.ON_CYC(ON_N), .OFF_CYC(OFF_N), .STABLE_CYC(ST_N)) u_mps_link_chk (
		.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .main_supply(link.main_supply),
		.power_key_n(link.power_key_n), .radio_off_n(link.radio_off_n),
		.cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cmd_arg(link.cmd_arg),
		.cmd_ack(link.cmd_ack), .cmd_err(link.cmd_err), .usb_remote_wake(link.usb_remote_wake),
		.module_status(link.module_status));
	always #12.5 ref_clk_i = ~ref_clk_i;
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr <= 1'b0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, exp);
	endtask : rchk
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask : tick
	// Expected answer as {err, ack} in status bits 3:2
	task automatic cmd(input mps_cmd_e c, input logic [2:0] arg, input logic [1:0] exp);
		wr(REG_CMD, {25'h0, arg, 2'h0, c});
		tick(5);
		rchk(REG_IRQ_STAT, {28'h0, exp, 2'h0}, 32'h0000000C);
		wr(REG_IRQ_STAT, 32'h0000000C);
	endtask : cmd
	task automatic stop_test;
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		mismatches++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		rchk(REG_CTRL, 32'h00000008, 32'hFFFFFFFF);
		rchk(REG_STATUS, 32'h0, 32'hFFFFFFFF);
		wr(8'h40, 32'hFFFFFFFF);
		rchk(8'h40, 32'h0, 32'hFFFFFFFF);
		$display("test reset done");
		wr(REG_CTRL, 32'h0000000A);
		tick(ST_N + ON_N + 8);
		chk(32'(pstate), 32'(PWR_ON));
		chk(32'(fun), 32'(FUN_FULL));
		rchk(REG_IRQ_STAT, 32'h10, 32'h10);
		chk(32'(irq), 32'h0);
		wr(REG_IRQ_MASK, 32'h10);
		tick(2);
		chk(32'(irq), 32'h1);
		wr(REG_IRQ_STAT, 32'h10);
		tick(2);
		chk(32'(irq), 32'h0);
		wr(REG_CTRL, 32'h00000008);
		tick(2);
		rchk(REG_CTRL, 32'h1, 32'h1);
		$display("test power_on done");
		cmd(CMD_FUN, 3'h0, 2'b01);
		chk(32'({rf_en, sim_en}), 32'h0);
		cmd(CMD_FUN, 3'h4, 2'b01);
		chk(32'({fun, rf_en, sim_en}), 32'h11);
		cmd(CMD_RF, 3'h0, 2'b10);
		cmd(CMD_FUN, 3'h2, 2'b10);
		cmd(CMD_SCLK, 3'h2, 2'b10);
		cmd(CMD_FUN, 3'h1, 2'b01);
		chk(32'({rf_en, sim_en}), 32'h3);
		cmd(CMD_RF, 3'h0, 2'b01);
		wr(REG_CTRL, 32'h00000049);
		tick(3);
		chk(32'(rf_en), 32'h0);
		cmd(CMD_RF, 3'h0, 2'b10);
		wr(REG_CTRL, 32'h00000009);
		$display("test commands done");
		cmd(CMD_SCLK, 3'h1, 2'b01);
		chk(32'(pstate), 32'(PWR_SLEEP));
		cmd(CMD_FUN, 3'h1, 2'b10);
		@(posedge ref_clk_i) unsolicited_result <= 1'b1;
		tick(3);
		chk(32'(link.ring_indicate_line), 32'h1);
		rchk(REG_IRQ_STAT, 32'h1, 32'h1);
		@(posedge ref_clk_i) unsolicited_result <= 1'b0;
		wr(REG_CTRL, 32'h00000001);
		tick(3);
		chk(32'(pstate), 32'(PWR_ON));
		$display("test serial sleep done");
		for (int s = 1; s < 4; s++) begin
			@(posedge ref_clk_i) scenario <= 2'(s);
			wr(REG_CTRL, (s == 3) ? 32'h09 : 32'h39);
			tick(3);
			chk(32'(pstate), 32'(PWR_SLEEP));
			@(posedge ref_clk_i) unsolicited_result <= 1'b1;
			tick(3);
			chk(32'({link.usb_remote_wake, link.ring_indicate_line}), (s == 1) ? 2 : (s == 2));
			@(posedge ref_clk_i) unsolicited_result <= 1'b0;
			// In scenarios 1 and 2 suspend stays up, so the module may doze again right after waking
			wr(REG_CTRL, (s == 3) ? 32'h29 : 32'h239);
			seen = 1'b0;
			repeat (4) begin
				@(posedge ref_clk_i);
				#1 seen = seen | (pstate === PWR_ON);
			end
			chk(32'(seen), 32'h1);
			wr(REG_CTRL, 32'h21);
			tick(2);
			$display("test usb scenario %0d done", s);
		end
		wr(REG_CTRL, 32'h181);
		tick(3);
		chk(32'(sstate), 32'(SN_ACQ));
		@(posedge ref_clk_i) acq <= 1'b1;
		tick(3);
		chk(32'(sstate), 32'(SN_TRACK));
		wr(REG_CTRL, 32'h185);
		tick(OFF_N + 6);
		chk(32'(pstate), 32'(PWR_OFF));
		chk(32'(sstate), 32'(SN_OFF));
		wr(REG_CTRL, 32'h0);
		tick(2);
		rchk(REG_CTRL, 32'h0, 32'h1);
		$display("test satnav and power_off done");
		// Second turn-on, then turn-off by command and a stand-alone satnav
		wr(REG_CTRL, 32'h0000000B);
		tick(ST_N + ON_N + 8);
		chk(32'(pstate), 32'(PWR_ON));
		cmd(CMD_PWROFF, 3'h0, 2'b01);
		tick(1);
		chk(32'(pstate), 32'(PWR_OFF));
		@(posedge ref_clk_i);
		combined <= 1'b0;
		acq <= 1'b0;
		wr(REG_CTRL, 32'h00000180);
		tick(3);
		chk(32'(sstate), 32'(SN_ACQ));
		rchk(REG_CTRL, 32'h0, 32'h1);
		$display("test command power_off done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire

// file: design/mps_host_ctl.sv
// Purpose: Host end: drives module pins and commands from a register port
// Assumes: Software strobes are one cycle, read data one cycle later
// Notes: Supply settle and key press lengths are parameters
`timescale 1ns/100ps
`default_nettype none
module mps_host_ctl import mps_pkg::*; #(
	parameter int unsigned ON_CYC = ms_cyc(POWER_KEY_N_ON_MS),
	parameter int unsigned OFF_CYC = ms_cyc(POWER_KEY_N_OFF_MS),
	parameter int unsigned STABLE_CYC = ms_cyc(SUPPLY_STABLE_MS)
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	output logic irq_o,
	// Link to module
	mps_link_if.host link
);

	typedef struct packed {
		mps_hseq_e seq;
		logic [31:0] cnt;
		logic [31:0] stable_cnt;
		logic off_press;
		logic [9:0] ctrl;
		logic key_n;
		logic usb_data;
		logic cmd_valid;
		mps_cmd_e code;
		logic [2:0] arg;
		logic busy;
		logic last_err;
		logic ring_q;
		logic rwake_q;
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic [31:0] rdata;
		logic irq;
	} mps_host_s;

	mps_host_s s_q;
	mps_host_s s_d;
	logic wr_ctrl;
	logic [IRQ_W-1:0] ev;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		s_d.usb_data = 1'b0;
		s_d.cmd_valid = 1'b0;
		s_d.rdata = 32'h0;
		ev = '0;
		wr_ctrl = reg_wr_i && (reg_addr_i == REG_CTRL);

		if (wr_ctrl) begin
			s_d.ctrl[CTRL_SN_BKUP:CTRL_WAKE] = reg_wdata_i[CTRL_SN_BKUP:CTRL_WAKE];
			s_d.usb_data = reg_wdata_i[CTRL_USB_SEND];
			// Supply may only drop once the module is off and no press runs
			if (reg_wdata_i[CTRL_SUPPLY] || (!link.module_status && s_q.seq == HS_IDLE)) begin
				s_d.ctrl[CTRL_SUPPLY] = reg_wdata_i[CTRL_SUPPLY];
			end
		end
		s_d.stable_cnt = s_d.ctrl[CTRL_SUPPLY] ? sat_inc(s_q.stable_cnt) : 32'h0;

		unique case (s_q.seq)
			HS_IDLE: begin
				if (wr_ctrl && reg_wdata_i[CTRL_PWR_ON] && !link.module_status) begin
					s_d.ctrl[CTRL_SUPPLY] = 1'b1;
					s_d.off_press = 1'b0;
					s_d.seq = HS_SETTLE;
				end else if (wr_ctrl && reg_wdata_i[CTRL_PWR_OFF] && link.module_status) begin
					s_d.off_press = 1'b1;
					s_d.cnt = 32'h0;
					s_d.key_n = 1'b0;
					s_d.seq = HS_PRESS;
				end
			end
			HS_SETTLE: begin
				if (s_q.stable_cnt >= STABLE_CYC) begin
					s_d.cnt = 32'h0;
					s_d.key_n = 1'b0;
					s_d.seq = HS_PRESS;
				end
			end
			HS_PRESS: begin
				s_d.cnt = sat_inc(s_q.cnt);
				if (s_d.cnt >= (s_q.off_press ? OFF_CYC : ON_CYC)) begin
					s_d.key_n = 1'b1;
					s_d.seq = HS_IDLE;
					ev[IRQ_SEQ] = 1'b1;
				end
			end
			default: s_d.seq = HS_IDLE;
		endcase

		// Command issue; a write while one is outstanding is dropped
		if (reg_wr_i && (reg_addr_i == REG_CMD) && !s_q.busy) begin
			s_d.cmd_valid = 1'b1;
			s_d.code = mps_cmd_e'(reg_wdata_i[CMD_CODE_LSB +: 2]);
			s_d.arg = reg_wdata_i[CMD_ARG_LSB +: 3];
			s_d.busy = 1'b1;
		end
		if (link.cmd_ack || link.cmd_err) begin
			s_d.busy = 1'b0;
			s_d.last_err = link.cmd_err;
		end

		s_d.ring_q = link.ring_indicate_line;
		s_d.rwake_q = link.usb_remote_wake;
		ev[IRQ_RING] = link.ring_indicate_line && !s_q.ring_q;
		ev[IRQ_RWAKE] = link.usb_remote_wake && !s_q.rwake_q;
		ev[IRQ_ACK] = link.cmd_ack;
		ev[IRQ_ERR] = link.cmd_err;

		// Set wins over a same-cycle write-one clear
		if (reg_wr_i && (reg_addr_i == REG_IRQ_STAT)) begin
			s_d.stat = s_q.stat & ~reg_wdata_i[IRQ_W-1:0];
		end
		s_d.stat = s_d.stat | ev;
		if (reg_wr_i && (reg_addr_i == REG_IRQ_MASK)) begin
			s_d.mask = reg_wdata_i[IRQ_W-1:0];
		end
		s_d.irq = |(s_d.stat & s_d.mask);

		if (reg_rd_i) begin
			unique case (reg_addr_i)
				REG_CTRL: s_d.rdata = {22'h0, s_q.ctrl};
				REG_CMD: s_d.rdata = {25'h0, s_q.arg, 2'h0, s_q.code};
				REG_STATUS: s_d.rdata = {25'h0, s_q.seq, link.usb_remote_wake,
					link.ring_indicate_line, s_q.last_err, s_q.busy, link.module_status};
				REG_IRQ_STAT: s_d.rdata = {27'h0, s_q.stat};
				REG_IRQ_MASK: s_d.rdata = {27'h0, s_q.mask};
				default: s_d.rdata = 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '{seq: HS_IDLE, cnt: 32'h0, stable_cnt: 32'h0, off_press: 1'b0,
				ctrl: 10'h008, key_n: 1'b1, usb_data: 1'b0, cmd_valid: 1'b0,
				code: CMD_SCLK, arg: 3'h0, busy: 1'b0, last_err: 1'b0, ring_q: 1'b0,
				rwake_q: 1'b0, stat: '0, mask: '0, rdata: 32'h0, irq: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata_o = s_q.rdata;
	assign irq_o = s_q.irq;
	assign link.main_supply = s_q.ctrl[CTRL_SUPPLY];
	assign link.power_key_n = s_q.key_n;
	assign link.term_ready = s_q.ctrl[CTRL_WAKE];
	assign link.usb_suspend = s_q.ctrl[CTRL_SUSPEND];
	assign link.bus_power_sense = s_q.ctrl[CTRL_BUS_PWR];
	assign link.radio_off_n = !s_q.ctrl[CTRL_RADIO_OFF];
	assign link.satnav_power_enable = s_q.ctrl[CTRL_SN_EN];
	assign link.satnav_backup_supply = s_q.ctrl[CTRL_SN_BKUP];
	assign link.usb_data = s_q.usb_data;
	assign link.cmd_valid = s_q.cmd_valid;
	assign link.cmd_code = s_q.code;
	assign link.cmd_arg = s_q.arg;

endmodule : mps_host_ctl
`default_nettype wire

// file: design/mps_module_dev.sv
// Purpose: Module end: power key, sleep/wake, functionality level, satnav modes
// Assumes: Link inputs synchronous to ref_clk_i
// Notes: Press lengths are parameters so simulation can shorten them
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Key low 500 ms from off turns on
// - Host waits 30 ms stable supply first
// - Sleep needs sleep-clock 1, terminal-ready high
// - Terminal-ready low wakes the module
// - Serial link: ring line flags pending result
// - USB suspend scenarios also need bus suspended
// - Remote wakeup signalling for pending results
// - USB data from host wakes module
// - Suspend without remote wake uses ring line
// - No suspend: bus power off sleeps, restore wakes
// - Radio-off low forces airplane, rejects RF commands
// - Functionality levels 0, 1, 4 accepted
// - Satnav continuous with enable and backup supply
// - Satnav acquires, then tracks automatically
// - Combined: satnav dead while cellular off
// - Host cuts supply only after turn-off
// - Key low 650 ms then release turns off
module mps_module_dev import mps_pkg::*; #(
	parameter int unsigned ON_CYC = ms_cyc(POWER_KEY_N_ON_MS),
	parameter int unsigned OFF_CYC = ms_cyc(POWER_KEY_N_OFF_MS)
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// Link to host
	mps_link_if.dev link,
	// Configuration straps
	input wire logic [1:0] scenario_i,
	input wire logic combined_i,
	// Internal events
	input wire logic urc_pending_i,
	input wire logic acq_done_i,
	// Observed state
	output logic [1:0] power_state_o,
	output logic [2:0] fun_level_o,
	output logic rf_enable_o,
	output logic sim_enable_o,
	output logic [1:0] satnav_state_o
);

	typedef struct packed {
		mps_pwr_e st;
		logic [31:0] key_cnt;
		logic key_armed;
		logic sclk;
		logic [2:0] fun;
		logic ack;
		logic err;
		logic ring;
		logic rwake;
		logic status;
		logic rf_en;
		logic sim_en;
		mps_sn_e sn;
	} mps_dev_s;

	mps_dev_s s_q;
	mps_dev_s s_d;
	logic [31:0] kcnt_n;
	logic off_req;
	logic sleep_ok;
	logic wake;
	logic sn_pwr_ok;
	logic usb_susp_scen;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		s_d.err = 1'b0;
		kcnt_n = link.power_key_n ? 32'h0 : sat_inc(s_q.key_cnt);
		s_d.key_cnt = kcnt_n;
		// A held key only counts once it has been seen high again
		if (link.power_key_n) begin
			s_d.key_armed = 1'b1;
		end
		off_req = s_q.key_armed && link.power_key_n && (s_q.key_cnt >= OFF_CYC);
		usb_susp_scen = (scenario_i == SCEN_USB_RWAKE) || (scenario_i == SCEN_USB_RI);
		unique case (scenario_i)
			SCEN_UART: sleep_ok = 1'b1;
			SCEN_USB_RWAKE, SCEN_USB_RI: sleep_ok = link.usb_suspend;
			SCEN_USB_NOSUSP: sleep_ok = !link.bus_power_sense;
		endcase
		sleep_ok = sleep_ok && s_q.sclk && link.term_ready;
		wake = !link.term_ready;
		if (usb_susp_scen && (link.usb_data || !link.usb_suspend)) begin
			wake = 1'b1;
		end
		if ((scenario_i == SCEN_USB_NOSUSP) && link.bus_power_sense) begin
			wake = 1'b1;
		end

		unique case (s_q.st)
			PWR_OFF: begin
				if (link.main_supply && s_q.key_armed && (kcnt_n >= ON_CYC)) begin
					s_d.st = PWR_ON;
					s_d.key_armed = 1'b0;
					s_d.fun = FUN_FULL;
					s_d.sclk = 1'b0;
				end
			end
			PWR_ON: begin
				if (off_req) begin
					s_d.st = PWR_OFF;
				end else if (sleep_ok) begin
					s_d.st = PWR_SLEEP;
				end
			end
			PWR_SLEEP: begin
				if (off_req) begin
					s_d.st = PWR_OFF;
				end else if (wake) begin
					s_d.st = PWR_ON;
				end
			end
		endcase

		// Commands are only served while awake
		if (link.cmd_valid) begin
			if (s_q.st != PWR_ON) begin
				s_d.err = 1'b1;
			end else begin
				unique case (link.cmd_code)
					CMD_SCLK: begin
						if (link.cmd_arg <= 3'h1) begin
							s_d.sclk = link.cmd_arg[0];
							s_d.ack = 1'b1;
						end else begin
							s_d.err = 1'b1;
						end
					end
					CMD_FUN: begin
						if ((link.cmd_arg == FUN_MIN) || (link.cmd_arg == FUN_FULL)
								|| (link.cmd_arg == FUN_AIR)) begin
							s_d.fun = link.cmd_arg;
							s_d.ack = 1'b1;
						end else begin
							s_d.err = 1'b1;
						end
					end
					CMD_RF: begin
						// Pin checked directly: the registered enable lags it by a cycle
						if (s_q.rf_en && link.radio_off_n) begin
							s_d.ack = 1'b1;
						end else begin
							s_d.err = 1'b1;
						end
					end
					CMD_PWROFF: begin
						s_d.ack = 1'b1;
						s_d.st = PWR_OFF;
					end
				endcase
			end
		end

		// Supply loss drops the cellular part to off, no turn-off procedure possible
		if (!link.main_supply) begin
			s_d.st = PWR_OFF;
		end

		s_d.status = (s_d.st != PWR_OFF);
		s_d.rf_en = s_d.status && (s_d.fun == FUN_FULL) && link.radio_off_n;
		s_d.sim_en = s_d.status && (s_d.fun != FUN_MIN);
		s_d.ring = urc_pending_i && s_d.status
			&& ((scenario_i == SCEN_UART) || (scenario_i == SCEN_USB_RI));
		s_d.rwake = urc_pending_i && (s_d.st == PWR_SLEEP)
			&& (scenario_i == SCEN_USB_RWAKE) && link.usb_suspend;

		// Satnav: powered either by the cellular part or on its own
		sn_pwr_ok = link.satnav_power_enable && link.satnav_backup_supply
			&& (!combined_i || s_d.status);
		if (!sn_pwr_ok) begin
			s_d.sn = SN_OFF;
		end else begin
			unique case (s_q.sn)
				SN_OFF: s_d.sn = SN_ACQ;
				SN_ACQ: begin
					if (acq_done_i) begin
						s_d.sn = SN_TRACK;
					end
				end
				SN_TRACK: s_d.sn = SN_TRACK;
				default: s_d.sn = SN_OFF;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_q <= '{st: PWR_OFF, key_cnt: 32'h0, key_armed: 1'b1, sclk: 1'b0,
				fun: FUN_FULL, ack: 1'b0, err: 1'b0, ring: 1'b0, rwake: 1'b0,
				status: 1'b0, rf_en: 1'b0, sim_en: 1'b0, sn: SN_OFF};
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign link.cmd_ack = s_q.ack;
	assign link.cmd_err = s_q.err;
	assign link.ring_indicate_line = s_q.ring;
	assign link.usb_remote_wake = s_q.rwake;
	assign link.module_status = s_q.status;
	assign power_state_o = s_q.st;
	assign fun_level_o = s_q.fun;
	assign rf_enable_o = s_q.rf_en;
	assign sim_enable_o = s_q.sim_en;
	assign satnav_state_o = s_q.sn;

endmodule : mps_module_dev
`default_nettype wire

// file: inc/mps_link_if.sv
// Purpose: Pins and command channel between host controller and module
// Assumes: Both ends on ref_clk_i; all signals synchronous
// Notes: Commands are a one-cycle valid with code and argument
`timescale 1ns/100ps
`default_nettype none
interface mps_link_if;
	import mps_pkg::*;
	logic main_supply;
	logic power_key_n;
	logic term_ready;
	logic radio_off_n;
	logic bus_power_sense;
	logic usb_suspend;
	logic usb_data;
	logic satnav_power_enable;
	logic satnav_backup_supply;
	logic cmd_valid;
	mps_cmd_e cmd_code;
	logic [2:0] cmd_arg;
	logic cmd_ack;
	logic cmd_err;
	logic ring_indicate_line;
	logic usb_remote_wake;
	logic module_status;

	modport dev (
		input main_supply, power_key_n, term_ready, radio_off_n, bus_power_sense,
		input usb_suspend, usb_data, satnav_power_enable, satnav_backup_supply,
		input cmd_valid, cmd_code, cmd_arg,
		output cmd_ack, cmd_err, ring_indicate_line, usb_remote_wake, module_status
	);

	modport host (
		output main_supply, power_key_n, term_ready, radio_off_n, bus_power_sense,
		output usb_suspend, usb_data, satnav_power_enable, satnav_backup_supply,
		output cmd_valid, cmd_code, cmd_arg,
		input cmd_ack, cmd_err, ring_indicate_line, usb_remote_wake, module_status
	);
endinterface : mps_link_if
`default_nettype wire

// file: inc/mps_pkg.sv
// Purpose: Shared constants and types for the module power/sleep control pair
// Assumes: 40 MHz ref_clk_i on both ends
// Notes: Long press times are turned into cycle counts by ms_cyc
package mps_pkg;

	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned POWER_KEY_N_ON_MS = 500;
	localparam int unsigned POWER_KEY_N_OFF_MS = 650;
	localparam int unsigned SUPPLY_STABLE_MS = 30;

	// Functionality levels
	localparam logic [2:0] FUN_MIN = 3'h0;
	localparam logic [2:0] FUN_FULL = 3'h1;
	localparam logic [2:0] FUN_AIR = 3'h4;

	// Host connection scenarios
	localparam logic [1:0] SCEN_UART = 2'h0;
	localparam logic [1:0] SCEN_USB_RWAKE = 2'h1;
	localparam logic [1:0] SCEN_USB_RI = 2'h2;
	localparam logic [1:0] SCEN_USB_NOSUSP = 2'h3;

	// Host register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;

	// Control register fields
	localparam int CTRL_SUPPLY = 0;
	localparam int CTRL_PWR_ON = 1;
	localparam int CTRL_PWR_OFF = 2;
	localparam int CTRL_WAKE = 3;
	localparam int CTRL_SUSPEND = 4;
	localparam int CTRL_BUS_PWR = 5;
	localparam int CTRL_RADIO_OFF = 6;
	localparam int CTRL_SN_EN = 7;
	localparam int CTRL_SN_BKUP = 8;
	localparam int CTRL_USB_SEND = 9;

	// Command register fields: code in [1:0], argument in [6:4]
	localparam int CMD_CODE_LSB = 0;
	localparam int CMD_ARG_LSB = 4;

	// Interrupt event bits
	localparam int IRQ_RING = 0;
	localparam int IRQ_RWAKE = 1;
	localparam int IRQ_ACK = 2;
	localparam int IRQ_ERR = 3;
	localparam int IRQ_SEQ = 4;
	localparam int IRQ_W = 5;

	typedef enum logic [1:0] {
		CMD_SCLK = 2'b00,
		CMD_FUN = 2'b01,
		CMD_RF = 2'b10,
		CMD_PWROFF = 2'b11
	} mps_cmd_e;

	typedef enum logic [1:0] {
		PWR_OFF = 2'b00,
		PWR_ON = 2'b01,
		PWR_SLEEP = 2'b10
	} mps_pwr_e;

	typedef enum logic [1:0] {
		SN_OFF = 2'b00,
		SN_ACQ = 2'b01,
		SN_TRACK = 2'b10
	} mps_sn_e;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_SETTLE = 2'b01,
		HS_PRESS = 2'b10
	} mps_hseq_e;

	function automatic int unsigned ms_cyc(input int unsigned ms);
		return ms * (CLK_HZ / 1000);
	endfunction : ms_cyc

	function automatic logic [31:0] sat_inc(input logic [31:0] v);
		return (v == 32'hFFFFFFFF) ? v : v + 32'h1;
	endfunction : sat_inc

endpackage : mps_pkg
